// File: sssrc_pkg.sv
// package: register map, field layouts, levels and timing for the supply supervisor
package sssrc_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    // start-up delays in microseconds
    localparam int unsigned STARTUP_BOR_US = 3300;
    localparam int unsigned STARTUP_NOBOR_US = 1000;
    localparam int unsigned STARTUP_BOR_CYC = (STARTUP_BOR_US * (CLK_HZ / 1_000_000));
    localparam int unsigned STARTUP_NOBOR_CYC = (STARTUP_NOBOR_US * (CLK_HZ / 1_000_000));
    localparam int unsigned CNT_W = 18;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_INT_STAT = 8'h08;
    localparam logic [7:0] REG_INT_EN = 8'h0c;
    localparam logic [7:0] REG_INT_CLR = 8'h10;
    localparam logic [7:0] REG_OPT = 8'h14;

    // control fields
    localparam int unsigned CTRL_DET_EN = 0;
    localparam int unsigned CTRL_LVL_LO = 1;
    localparam int unsigned CTRL_LVL_HI = 3;
    localparam int unsigned CTRL_FALL_EN = 4;
    localparam int unsigned CTRL_RISE_EN = 5;
    localparam int unsigned CTRL_REF_STOP_OFF = 6;
    localparam int unsigned CTRL_PMODE_LO = 8;
    localparam int unsigned CTRL_PMODE_HI = 10;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_077f;

    // interrupt status bits
    localparam int unsigned INT_W = 3;
    localparam int unsigned INT_FALL = 0;
    localparam int unsigned INT_RISE = 1;
    localparam int unsigned INT_READY = 2;

    // option byte layout: [0] brownout disable, [3:1] brownout level
    localparam int unsigned OPT_BOR_DIS = 0;
    localparam int unsigned OPT_BOR_LO = 1;
    localparam int unsigned OPT_BOR_HI = 3;
    localparam logic [7:0] OPT_DEFAULT = 8'h00;
    localparam logic [2:0] BOR_LEVEL_MAX = 3'h4;
    localparam logic [2:0] DET_LEVEL_MAX = 3'h6;

    typedef enum logic [2:0] {
        SSSRC_PM_RUN,
        SSSRC_PM_SLEEP,
        SSSRC_PM_LP_RUN,
        SSSRC_PM_LP_SLEEP,
        SSSRC_PM_STOP,
        SSSRC_PM_STANDBY
    } sssrc_pmode_t;

    typedef enum logic [1:0] {
        SSSRC_REG_MAIN,
        SSSRC_REG_LOW_POWER,
        SSSRC_REG_POWER_DOWN
    } sssrc_reg_mode_t;
endpackage : sssrc_pkg

// File: sssrc_rst_sync.sv
// reset release synchroniser: asynchronous assert, clocked release
`timescale 1ns/100ps
module sssrc_rst_sync (
    input wire logic hclk,
    input wire logic arst_n,
    output logic srst_n
);
    logic meta_q;
    logic hold_q;

    always_ff @(posedge hclk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b0;
            hold_q <= 1'b0;
        end else begin
            meta_q <= 1'b1;
            hold_q <= meta_q;
        end
    end

    assign srst_n = hold_q;
endmodule : sssrc_rst_sync

// File: sssrc_det_edge.sv
// voltage detector crossing detector: sync and edge events
`timescale 1ns/100ps
module sssrc_det_edge (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic enable,
    input wire logic below_in,
    output logic below,
    output logic fall_evt,
    output logic rise_evt
);
    logic s1_q;
    logic s2_q;
    logic prev_q;
    logic armed_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else if (clk_en) begin
            s1_q <= below_in;
            s2_q <= s1_q;
        end
    end

    // armed one cycle after enable so enabling never fakes an edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_q <= 1'b0;
            armed_q <= 1'b0;
        end else if (clk_en) begin
            prev_q <= s2_q;
            armed_q <= enable;
        end
    end

    assign below = s2_q;
    assign fall_evt = enable && armed_q && s2_q && !prev_q;
    assign rise_evt = enable && armed_q && !s2_q && prev_q;
endmodule : sssrc_det_edge

// File: sssrc_top.sv
// supply supervisor and regulator mode controller with AHB-Lite registers
// Overview of operation
// - hold system reset while supply is below power-on or brownout threshold
// - on threshold release, load option bytes before normal operation
// - option bytes keep, change or permanently disable the brownout supervisor
// - brownout level is one of five, taken only from option bytes
// - optional automatic reference switch-off whenever Stop mode is entered
// - detector threshold is software-chosen among seven levels
// - detector interrupts on falling, rising, or both crossings
// - detector inactive until software enables it
// - main regulator mode in Run mode
// - low-power regulator in low-power run, low-power sleep and Stop
// - regulator powered down, output high impedance, in Standby
// - Standby drops core state; only the standby domain keeps its state
// - start-up delay 3.3 ms with brownout, 1 ms without
`timescale 1ns/100ps
module sssrc_top #(
    parameter int unsigned STARTUP_BOR_CYC = sssrc_pkg::STARTUP_BOR_CYC,
    parameter int unsigned STARTUP_NOBOR_CYC = sssrc_pkg::STARTUP_NOBOR_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // analog comparators, high means supply below that threshold
    input wire logic por_below,
    input wire logic bor_below,
    input wire logic det_below,
    // option byte source
    input wire logic [7:0] opt_byte,
    input wire logic opt_valid,
    output logic opt_load_req,
    // power mode request from the power controller
    input wire logic [2:0] power_mode,
    // analog control outputs
    output logic [2:0] brownout_level,
    output logic brownout_enable,
    output logic [2:0] detector_threshold_level,
    output logic detector_enable,
    output logic internal_voltage_reference_on,
    output logic [1:0] regulator_mode,
    output logic regulator_out_hiz,
    output logic core_domain_reset_n,
    output logic sys_reset_n,
    output logic irq
);
    typedef enum logic [1:0] {
        SSSRC_ST_RESET,
        SSSRC_ST_OPT_LOAD,
        SSSRC_ST_STARTUP,
        SSSRC_ST_RUN
    } sssrc_seq_t;

    function automatic logic [2:0] sat_level(input logic [2:0] v, input logic [2:0] max);
        sat_level = (v > max) ? max : v;
    endfunction : sat_level

    // start-up length depends on whether brownout was active at power-up
    function automatic logic startup_done(input logic bor_active, input logic [sssrc_pkg::CNT_W-1:0] cnt);
        if (bor_active) begin
            startup_done = (cnt >= sssrc_pkg::CNT_W'(STARTUP_BOR_CYC - 1));
        end else begin
            startup_done = (cnt >= sssrc_pkg::CNT_W'(STARTUP_NOBOR_CYC - 1));
        end
    endfunction : startup_done

    function automatic logic wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] reg_off);
        wr_hit = wr && (addr == reg_off);
    endfunction : wr_hit

    logic bor_dis_q;
    logic [2:0] bor_lvl_q;
    logic bor_seen_q;
    logic supply_low;
    logic arst_n;
    logic srst_n;
    sssrc_seq_t state_q;
    logic [sssrc_pkg::CNT_W-1:0] cnt_q;
    logic [31:0] ctrl_q;
    logic [sssrc_pkg::INT_W-1:0] int_stat_q;
    logic [sssrc_pkg::INT_W-1:0] int_en_q;
    logic [sssrc_pkg::INT_W-1:0] int_set;
    logic [sssrc_pkg::INT_W-1:0] int_clr;
    logic ready_evt;
    logic det_below_s;
    logic fall_evt;
    logic rise_evt;
    logic ph_wr_q;
    logic [7:0] ph_addr_q;
    sssrc_pkg::sssrc_pmode_t pmode;

    // supply low reset; brownout counts unless disabled by option bytes
    assign supply_low = por_below || (brownout_enable && bor_below);
    assign arst_n = hresetn && !supply_low;

    sssrc_rst_sync u_rst_sync (
        .hclk(hclk),
        .arst_n(arst_n),
        .srst_n(srst_n)
    );

    // option byte capture; disable stays set until power is lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bor_dis_q <= sssrc_pkg::OPT_DEFAULT[sssrc_pkg::OPT_BOR_DIS];
            bor_lvl_q <= sssrc_pkg::OPT_DEFAULT[sssrc_pkg::OPT_BOR_HI:sssrc_pkg::OPT_BOR_LO];
        end else if (clk_en && state_q == SSSRC_ST_OPT_LOAD && opt_valid) begin
            bor_dis_q <= bor_dis_q | opt_byte[sssrc_pkg::OPT_BOR_DIS];
            bor_lvl_q <= sat_level(opt_byte[sssrc_pkg::OPT_BOR_HI:sssrc_pkg::OPT_BOR_LO],
                sssrc_pkg::BOR_LEVEL_MAX);
        end
    end

    // brownout was active at power-up unless disabled, which shortens start-up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bor_seen_q <= !sssrc_pkg::OPT_DEFAULT[sssrc_pkg::OPT_BOR_DIS];
        end else if (clk_en && state_q == SSSRC_ST_OPT_LOAD && opt_valid) begin
            bor_seen_q <= !(bor_dis_q | opt_byte[sssrc_pkg::OPT_BOR_DIS]);
        end
    end

    assign brownout_enable = !bor_dis_q;
    assign brownout_level = bor_lvl_q;

    // sequence: reset, option load, start-up delay, run
    always_ff @(posedge hclk or negedge srst_n) begin
        if (!srst_n) begin
            state_q <= SSSRC_ST_RESET;
            cnt_q <= '0;
        end else if (clk_en) begin
            case (state_q)
                SSSRC_ST_RESET: begin
                    state_q <= SSSRC_ST_OPT_LOAD;
                end
                SSSRC_ST_OPT_LOAD: begin
                    if (opt_valid) begin
                        state_q <= SSSRC_ST_STARTUP;
                        cnt_q <= '0;
                    end
                end
                SSSRC_ST_STARTUP: begin
                    if (startup_done(bor_seen_q, cnt_q)) begin
                        state_q <= SSSRC_ST_RUN;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                SSSRC_ST_RUN: begin
                    state_q <= SSSRC_ST_RUN;
                end
                default: begin
                    state_q <= SSSRC_ST_RESET;
                end
            endcase
        end
    end

    assign opt_load_req = (state_q == SSSRC_ST_OPT_LOAD);
    // system reset held until sequence done
    assign sys_reset_n = (state_q == SSSRC_ST_RUN);
    assign ready_evt = clk_en && state_q == SSSRC_ST_STARTUP && startup_done(bor_seen_q, cnt_q);

    assign pmode = sssrc_pkg::sssrc_pmode_t'(power_mode);

    always_comb begin
        regulator_mode = sssrc_pkg::SSSRC_REG_MAIN;
        regulator_out_hiz = 1'b0;
        case (pmode)
            sssrc_pkg::SSSRC_PM_RUN, sssrc_pkg::SSSRC_PM_SLEEP: begin
                regulator_mode = sssrc_pkg::SSSRC_REG_MAIN;
            end
            sssrc_pkg::SSSRC_PM_LP_RUN, sssrc_pkg::SSSRC_PM_LP_SLEEP, sssrc_pkg::SSSRC_PM_STOP: begin
                regulator_mode = sssrc_pkg::SSSRC_REG_LOW_POWER;
            end
            sssrc_pkg::SSSRC_PM_STANDBY: begin
                regulator_mode = sssrc_pkg::SSSRC_REG_POWER_DOWN;
                regulator_out_hiz = 1'b1;
            end
            default: begin
                regulator_mode = sssrc_pkg::SSSRC_REG_MAIN;
            end
        endcase
    end

    // core domain reset in Standby; registers below are cleared
    assign core_domain_reset_n = srst_n && (pmode != sssrc_pkg::SSSRC_PM_STANDBY);

    // reference off in Stop when enabled
    assign internal_voltage_reference_on =
        !(ctrl_q[sssrc_pkg::CTRL_REF_STOP_OFF] && pmode == sssrc_pkg::SSSRC_PM_STOP);

    assign detector_enable = ctrl_q[sssrc_pkg::CTRL_DET_EN];
    assign detector_threshold_level =
        sat_level(ctrl_q[sssrc_pkg::CTRL_LVL_HI:sssrc_pkg::CTRL_LVL_LO], sssrc_pkg::DET_LEVEL_MAX);

    sssrc_det_edge u_det_edge (
        .hclk(hclk),
        .hresetn(core_domain_reset_n),
        .clk_en(clk_en),
        .enable(detector_enable),
        .below_in(det_below),
        .below(det_below_s),
        .fall_evt(fall_evt),
        .rise_evt(rise_evt)
    );

    // ahb-lite address phase capture; zero wait states while clk_en is high
    always_ff @(posedge hclk or negedge core_domain_reset_n) begin
        if (!core_domain_reset_n) begin
            ph_wr_q <= 1'b0;
            ph_addr_q <= 8'h00;
        end else if (clk_en && hready) begin
            ph_wr_q <= hsel && htrans[1] && hwrite;
            ph_addr_q <= haddr[7:0];
        end
    end

    // stall the bus while frozen so no transfer is acknowledged and lost
    assign hreadyout = clk_en;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge core_domain_reset_n) begin
        if (!core_domain_reset_n) begin
            ctrl_q <= sssrc_pkg::CTRL_RESET;
        end else if (clk_en && wr_hit(ph_wr_q, ph_addr_q, sssrc_pkg::REG_CTRL)) begin
            ctrl_q <= hwdata & sssrc_pkg::CTRL_MASK;
        end
    end

    always_ff @(posedge hclk or negedge core_domain_reset_n) begin
        if (!core_domain_reset_n) begin
            int_en_q <= '0;
        end else if (clk_en && wr_hit(ph_wr_q, ph_addr_q, sssrc_pkg::REG_INT_EN)) begin
            int_en_q <= hwdata[sssrc_pkg::INT_W-1:0];
        end
    end

    always_comb begin
        int_set = '0;
        int_set[sssrc_pkg::INT_FALL] = fall_evt && ctrl_q[sssrc_pkg::CTRL_FALL_EN];
        int_set[sssrc_pkg::INT_RISE] = rise_evt && ctrl_q[sssrc_pkg::CTRL_RISE_EN];
        int_set[sssrc_pkg::INT_READY] = ready_evt;
    end

    assign int_clr = wr_hit(ph_wr_q, ph_addr_q, sssrc_pkg::REG_INT_CLR) ?
        hwdata[sssrc_pkg::INT_W-1:0] : '0;

    // set wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge core_domain_reset_n) begin
        if (!core_domain_reset_n) begin
            int_stat_q <= '0;
        end else if (clk_en) begin
            int_stat_q <= (int_stat_q & ~int_clr) | int_set;
        end
    end

    assign irq = |(int_stat_q & int_en_q);

    // read data registered from the address phase decode
    always_ff @(posedge hclk or negedge core_domain_reset_n) begin
        if (!core_domain_reset_n) begin
            hrdata <= 32'h0000_0000;
        end else if (clk_en) begin
            hrdata <= 32'h0000_0000;
            if (hready && hsel && htrans[1] && !hwrite) begin
                case (haddr[7:0])
                    sssrc_pkg::REG_CTRL: hrdata <= ctrl_q;
                    sssrc_pkg::REG_STATUS: hrdata <= {26'h0, regulator_mode, det_below_s,
                        brownout_enable, sys_reset_n, 1'b0};
                    sssrc_pkg::REG_INT_STAT: hrdata <= {29'h0, int_stat_q};
                    sssrc_pkg::REG_INT_EN: hrdata <= {29'h0, int_en_q};
                    sssrc_pkg::REG_OPT: hrdata <= {28'h0, bor_lvl_q, bor_dis_q};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule : sssrc_top

// File: sssrc_sva.sv
// checker: supervisor sequencing and regulator mode assertions
`timescale 1ns/100ps
module sssrc_sva #(
    parameter int unsigned STARTUP_BOR_CYC = 20,
    parameter int unsigned STARTUP_NOBOR_CYC = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic por_below,
    input wire logic opt_load_req,
    input wire logic [2:0] power_mode,
    input wire logic [2:0] brownout_level,
    input wire logic brownout_enable,
    input wire logic [2:0] detector_threshold_level,
    input wire logic detector_enable,
    input wire logic internal_voltage_reference_on,
    input wire logic [1:0] regulator_mode,
    input wire logic regulator_out_hiz,
    input wire logic core_domain_reset_n,
    input wire logic sys_reset_n,
    input wire logic irq
);
    int unsigned cnt_q;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // cycles held in reset after the option load ends
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 0;
        end else if (opt_load_req || sys_reset_n) begin
            cnt_q <= 0;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
    AST_POR_HOLD: assert property (por_below |=> !sys_reset_n)
        else $error("reset released while supply low");
    AST_LOAD_FIRST: assert property (opt_load_req |-> !sys_reset_n)
        else $error("option load during normal operation");
    AST_BOR_STICKY: assert property (sys_reset_n && !brownout_enable |=> !brownout_enable)
        else $error("brownout supervisor re-enabled");
    AST_BOR_LVL: assert property (brownout_level <= sssrc_pkg::BOR_LEVEL_MAX)
        else $error("brownout level out of range");
    AST_REF_STOP: assert property (!internal_voltage_reference_on |-> power_mode == 3'h4)
        else $error("reference off outside stop");
    AST_DET_LVL: assert property (detector_threshold_level <= sssrc_pkg::DET_LEVEL_MAX)
        else $error("detector level out of range");
    AST_DET_OFF: assert property ($rose(sys_reset_n) |-> !detector_enable)
        else $error("detector active before software enable");
    AST_REG_RUN: assert property (power_mode == 3'h0 |-> regulator_mode == sssrc_pkg::SSSRC_REG_MAIN)
        else $error("run mode not on main regulator");
    AST_REG_LP: assert property (power_mode inside {3'h2, 3'h3, 3'h4}
        |-> regulator_mode == sssrc_pkg::SSSRC_REG_LOW_POWER)
        else $error("low power mode not on low power regulator");
    AST_REG_PD: assert property (power_mode == 3'h5
        |-> regulator_mode == sssrc_pkg::SSSRC_REG_POWER_DOWN && regulator_out_hiz)
        else $error("standby regulator not powered down");
    AST_STBY_RST: assert property (power_mode == 3'h5 |-> !core_domain_reset_n)
        else $error("core domain kept in standby");
    AST_STARTUP: assert property ($rose(sys_reset_n) |->
        cnt_q == (brownout_enable ? STARTUP_BOR_CYC : STARTUP_NOBOR_CYC))
        else $error("start-up delay wrong");
    AST_SYNC_REL: assert property ($rose(hresetn) |-> !sys_reset_n && !core_domain_reset_n)
        else $error("reset released without synchronisation");
    COV_BOOT: cover property ($rose(sys_reset_n));
    COV_IRQ: cover property ($rose(irq));
    COV_STBY: cover property (power_mode == 3'h5);
    COV_NOBOR: cover property (sys_reset_n && !brownout_enable);
endmodule : sssrc_sva

bind sssrc_top sssrc_sva #(.STARTUP_BOR_CYC(STARTUP_BOR_CYC), .STARTUP_NOBOR_CYC(STARTUP_NOBOR_CYC)) u_sssrc_sva (
    .hclk, .hresetn, .por_below, .opt_load_req, .power_mode, .brownout_level, .brownout_enable,
    .detector_threshold_level, .detector_enable, .internal_voltage_reference_on, .regulator_mode,
    .regulator_out_hiz, .core_domain_reset_n, .sys_reset_n, .irq);

// File: sssrc_supply_model.sv
// supply side model: option byte store answering load requests
`timescale 1ns/100ps
module sssrc_supply_model (
    input wire logic hclk,
    input wire logic opt_load_req,
    input wire logic [7:0] opt_store,
    input wire logic [3:0] lat,
    output logic [7:0] opt_byte,
    output logic opt_valid
);
    logic [3:0] wait_q = 4'h0;
    initial begin
        opt_byte = 8'h5a;
        opt_valid = 1'b0;
    end
    // answer a load after lat cycles
    always @(posedge hclk) begin
        if (opt_load_req && wait_q >= lat) begin
            opt_valid <= 1'b1;
            opt_byte <= opt_store;
        end else begin
            // idle bus toggles so stale data never looks valid
            opt_valid <= 1'b0;
            opt_byte <= ~opt_byte;
        end
        wait_q <= opt_load_req ? wait_q + 4'h1 : 4'h0;
    end
endmodule : sssrc_supply_model

// File: tb.sv
// testbench: supervisor boot, detector interrupts and power modes
`timescale 1ns/100ps
module tb;
    logic hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0, regulator_mode;
    logic [2:0] hsize = 3'h2, power_mode = 3'h0, brownout_level, detector_threshold_level;
    logic por_below = 1'b1, bor_below = 1'b0, det_below = 1'b0;
    logic [7:0] opt_store = 8'h06, opt_byte;
    logic [3:0] lat = 4'h0;
    logic hreadyout, hresp, opt_valid, opt_load_req, brownout_enable, detector_enable;
    logic internal_voltage_reference_on, regulator_out_hiz, core_domain_reset_n, sys_reset_n, irq;
    int error_cnt = 0, cmp_count = 0;
    always #10 hclk = ~hclk;
    sssrc_top #(.STARTUP_BOR_CYC(20), .STARTUP_NOBOR_CYC(8)) u_sssrc_top (.hclk, .hresetn, .clk_en, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .por_below,
        .bor_below, .det_below, .opt_byte, .opt_valid, .opt_load_req, .power_mode, .brownout_level,
        .brownout_enable, .detector_threshold_level, .detector_enable, .internal_voltage_reference_on,
        .regulator_mode, .regulator_out_hiz, .core_domain_reset_n, .sys_reset_n, .irq);
    sssrc_supply_model u_sssrc_supply_model (.hclk, .opt_load_req, .opt_store, .lat, .opt_byte, .opt_valid);
    task conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task to(input int k);
        if (k >= 300) begin
            error_cnt++;
            conclude();
        end
    endtask : to
    // one single word transfer; entered just after a rising edge
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int k;
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 300);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 300);
        r = hrdata;
        chk(hresp, 1'b0);
        to(k);
    endtask : xfer
    task rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask : rd
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
        @(posedge hclk);
    endtask : wr
    task settle(input int n);
        int k;
        k = 0;
        while (!(opt_load_req && opt_valid) && k < 300) begin
            @(posedge hclk);
            k++;
        end
        to(k);
        k = 0;
        while (sys_reset_n !== 1'b1 && k < 300) begin
            @(posedge hclk);
            k++;
        end
        to(k);
        // edges counted include the one that first shows reset released
        chk(k, n + 1);
        @(posedge hclk);
    endtask : settle
    task boot(input logic [7:0] o, input int n);
        opt_store <= o;
        hresetn <= 1'b0;
        por_below <= 1'b1;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
        chk(sys_reset_n, 1'b0);
        chk(opt_load_req, 1'b0);
        por_below <= 1'b0;
        settle(n);
    endtask : boot
    initial begin
        int i;
        @(posedge hclk);
        boot(8'h06, 20);
        chk(brownout_level, 3'h3);
        rd(sssrc_pkg::REG_STATUS, 32'h6);
        rd(sssrc_pkg::REG_OPT, 32'h6);
        bor_below <= 1'b1;
        repeat (3) @(posedge hclk);
        chk(sys_reset_n, 1'b0);
        bor_below <= 1'b0;
        settle(20);
        $display("test boot done");
        rd(sssrc_pkg::REG_INT_STAT, 32'h4);
        wr(sssrc_pkg::REG_INT_EN, 32'h7);
        chk(irq, 1'b1);
        wr(sssrc_pkg::REG_INT_CLR, 32'h4);
        chk(irq, 1'b0);
        det_below <= 1'b1;
        repeat (6) @(posedge hclk);
        det_below <= 1'b0;
        repeat (6) @(posedge hclk);
        rd(sssrc_pkg::REG_INT_STAT, 32'h0);
        for (i = 0; i < 8; i++) begin
            wr(sssrc_pkg::REG_CTRL, 32'h31 | (i << 1));
            chk(detector_threshold_level, (i > 6) ? 6 : i);
        end
        chk(detector_enable, 1'b1);
        det_below <= 1'b1;
        repeat (6) @(posedge hclk);
        chk(irq, 1'b1);
        rd(sssrc_pkg::REG_INT_STAT, 32'h1);
        wr(sssrc_pkg::REG_INT_CLR, 32'h1);
        det_below <= 1'b0;
        repeat (6) @(posedge hclk);
        rd(sssrc_pkg::REG_INT_STAT, 32'h2);
        wr(sssrc_pkg::REG_INT_CLR, 32'h2);
        // falling crossings only, and a frozen clock enable must hold the event back
        wr(sssrc_pkg::REG_CTRL, 32'h11);
        clk_en <= 1'b0;
        det_below <= 1'b1;
        repeat (6) @(posedge hclk);
        chk(irq, 1'b0);
        clk_en <= 1'b1;
        repeat (6) @(posedge hclk);
        chk(irq, 1'b1);
        wr(sssrc_pkg::REG_INT_CLR, 32'h1);
        det_below <= 1'b0;
        repeat (6) @(posedge hclk);
        rd(sssrc_pkg::REG_INT_STAT, 32'h0);
        $display("test detector done");
        wr(sssrc_pkg::REG_CTRL, 32'h40);
        for (i = 0; i < 6; i++) begin
            power_mode <= i[2:0];
            repeat (2) @(posedge hclk);
            chk(regulator_mode, (i < 2) ? 0 : (i < 5) ? 1 : 2);
            chk(regulator_out_hiz, i == 5);
            chk(internal_voltage_reference_on, i != 4);
            chk(core_domain_reset_n, i != 5);
        end
        power_mode <= 3'h0;
        repeat (4) @(posedge hclk);
        rd(sssrc_pkg::REG_CTRL, 32'h0);
        rd(8'h20, 32'h0);
        $display("test power modes done");
        lat <= 4'h6;
        boot(8'h0f, 8);
        chk(brownout_enable, 1'b0);
        chk(brownout_level, 3'h4);
        bor_below <= 1'b1;
        repeat (4) @(posedge hclk);
        chk(sys_reset_n, 1'b1);
        bor_below <= 1'b0;
        rd(sssrc_pkg::REG_STATUS, 32'h2);
        $display("test brownout disable done");
        conclude();
    end
endmodule : tb
